// ==== hw/rtc_only_power_sequencer.sv ====
// rtc-only power sequencer: power-management register, wake pin,
// regulator shutdown and power-good controlled restart
// assumes a 40 MHz clk, an analog comparator flagging regulator output
// above threshold, and a classic wishbone master on the register port
`timescale 1ns/1ps
`include "rtc_pm_regs.svh"
module rtc_only_power_sequencer
  import rtc_pm_pkg::*;
#(
  parameter int WAKE_CYCLES = `WAKE_MIN_CYCLES,
  parameter int RESET_CYCLES = `SYS_RESET_CYCLES,
  parameter int VALID_CYCLES = `VALID_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // wake pin, open drain when driven
  input wire logic wake_pin_i,
  output logic wake_pin_o,
  output logic wake_pin_oe,
  // analog side
  input wire logic core_regulator_output,
  input wire logic rtc_alarm,
  output analog_ctrl_s analog,
  output logic supply_valid_signal,
  output logic rtc_isolate,
  output logic system_reset_n,
  output logic clock_out_enable,
  output logic idle_wake
);

  localparam int CNT_W = 12;
  localparam int RST_W = 8;
  localparam logic [15:0] PM_RESET = `PM_RESET_VALUE;

  logic rst_meta_n;
  logic rst_sync_n;
  pm_reg_s pm;
  seq_state_e state;
  seq_state_e next_state;
  logic [RST_W-1:0] reset_count;
  logic wake_level;
  logic wake_qualified;
  logic wake_qualified_d;
  logic wake_event;
  logic regulator_ok;
  logic cause_pin;
  logic cause_alarm;
  logic bus_req;
  logic bus_write;
  logic hit_pm;
  logic hit_status;
  logic powerdown_req;
  logic wake_as_input;
  logic wake_by_pin;
  logic wake_by_alarm;
  logic [15:0] pm_read;
  logic [15:0] status_read;
  logic [31:0] next_dat;
  logic reset_done;
  logic ramp_armed;

  // release of the async reset through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  wake_filter #(
    .MIN_CYCLES(WAKE_CYCLES),
    .CNT_W(CNT_W)
  ) u_wake (
    .clk(clk),
    .rst_n(rst_sync_n),
    .pin(wake_pin_i),
    .level(wake_level),
    .qualified(wake_qualified)
  );

  // comparator output is analog and may chatter while ramping
  wake_filter #(
    .MIN_CYCLES(VALID_CYCLES),
    .CNT_W(CNT_W)
  ) u_valid (
    .clk(clk),
    .rst_n(rst_sync_n),
    .pin(core_regulator_output),
    .level(),
    .qualified(regulator_ok)
  );

  // previous qualified level, for a single wake pulse
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_qualified_d <= 1'b0;
    end else begin
      wake_qualified_d <= wake_qualified;
    end
  end

  assign wake_event = wake_qualified & ~wake_qualified_d;

  assign wake_as_input = ~pm.wake_pin_direction;
  assign wake_by_pin = wake_event & wake_as_input;
  assign wake_by_alarm = rtc_alarm;

  assign powerdown_req = pm.regulator_powerdown_bit | pm.reference_powerdown_bit;

  // wishbone decode; ack lands one cycle after the request
  assign bus_req = cyc_i & stb_i;
  assign hit_pm = (adr_i == `PM_REG_ADDR);
  assign hit_status = (adr_i == `PM_STATUS_ADDR);
  // writes commit on the edge where the master sees ack
  assign bus_write = bus_req & we_i & ack_o & sel_i[0] & ~rtc_isolate;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req & ~ack_o;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pm <= pm_reg_s'(PM_RESET[`PM_FIELD_MSB:0]);
    end else if (bus_write && hit_pm) begin
      pm <= pm_reg_s'(dat_i[`PM_FIELD_MSB:0]);
    end else if (state == ST_OFF && (wake_by_pin || wake_by_alarm)) begin
      pm.regulator_powerdown_bit <= 1'b0;
      pm.reference_powerdown_bit <= 1'b0;
    end
  end

  // wake cause flags, write one to clear; a new cause wins
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cause_pin <= 1'b0;
      cause_alarm <= 1'b0;
    end else begin
      if (state == ST_OFF && wake_by_pin) begin
        cause_pin <= 1'b1;
      end else if (bus_write && hit_status && dat_i[`ST_BIT_CAUSE_PIN]) begin
        cause_pin <= 1'b0;
      end
      if (state == ST_OFF && wake_by_alarm) begin
        cause_alarm <= 1'b1;
      end else if (bus_write && hit_status && dat_i[`ST_BIT_CAUSE_ALARM]) begin
        cause_alarm <= 1'b0;
      end
    end
  end

  always_comb begin
    pm_read = '0;
    pm_read[`PM_FIELD_MSB:0] = pm;
  end

  always_comb begin
    status_read = '0;
    status_read[`ST_BIT_VALID] = supply_valid_signal;
    status_read[`ST_BIT_ISOLATE] = rtc_isolate;
    status_read[`ST_BIT_WAKE_PIN] = wake_level;
    status_read[`ST_BIT_CAUSE_PIN] = cause_pin;
    status_read[`ST_BIT_CAUSE_ALARM] = cause_alarm;
    status_read[`ST_BIT_STATE_LSB +: 5] = state;
  end

  // unmapped addresses read zero and still ack
  always_comb begin
    next_dat = '0;
    if (hit_pm) begin
      next_dat[15:0] = pm_read;
    end else if (hit_status) begin
      next_dat[15:0] = status_read;
    end
  end

  // read data captured as the request is taken
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dat_o <= '0;
    end else if (bus_req && !ack_o) begin
      dat_o <= next_dat;
    end
  end

  assign reset_done = (reset_count == RST_W'(RESET_CYCLES - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_ON: begin
        if (powerdown_req) begin
          next_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (wake_by_pin || wake_by_alarm) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (regulator_ok && ramp_armed) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (reset_done) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        next_state = ST_ON;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_ON;
    end else begin
      state <= next_state;
    end
  end

  // release hold counter, parked at its end value
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reset_count <= '0;
    end else if (state != ST_RELEASE) begin
      reset_count <= '0;
    end else if (!reset_done) begin
      reset_count <= reset_count + RST_W'(1);
    end
  end

  // stale threshold flag must not end the ramp
  // filter output lags shutdown by a few cycles; an early wake would see it
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ramp_armed <= 1'b0;
    end else if (state != ST_RAMP) begin
      ramp_armed <= 1'b0;
    end else if (!regulator_ok) begin
      ramp_armed <= 1'b1;
    end
  end

  // analog enables; reference kept on unless bit 2 asked for it
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      analog.core_regulator_enable_pin <= 1'b1;
      analog.por_enable <= 1'b1;
      analog.bandgap_enable <= 1'b1;
    end else if (next_state == ST_OFF) begin
      analog.core_regulator_enable_pin <= 1'b0;
      analog.por_enable <= 1'b0;
      analog.bandgap_enable <= ~pm.reference_powerdown_bit;
    end else begin
      analog.core_regulator_enable_pin <= 1'b1;
      analog.por_enable <= 1'b1;
      analog.bandgap_enable <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      supply_valid_signal <= 1'b1;
    end else begin
      supply_valid_signal <= (next_state != ST_OFF) && (next_state != ST_RAMP);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rtc_isolate <= 1'b0;
    end else begin
      rtc_isolate <= (next_state == ST_OFF) || (next_state == ST_RAMP);
    end
  end

  // rest of system held in reset
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      system_reset_n <= 1'b1;
    end else begin
      system_reset_n <= (next_state != ST_OFF) && (next_state != ST_RAMP)
        && (next_state != ST_RELEASE);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_pin_oe <= 1'b0;
    end else begin
      wake_pin_oe <= pm.wake_pin_direction & ~pm.wake_pin_output_level;
    end
  end

  assign wake_pin_o = 1'b0;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_out_enable <= 1'b0;
    end else begin
      clock_out_enable <= pm.clock_output_enable;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      idle_wake <= 1'b0;
    end else begin
      idle_wake <= wake_by_pin & (state == ST_ON);
    end
  end

endmodule : rtc_only_power_sequencer

// ==== hw/rtc_pm_regs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and a 32-bit classic wishbone slave port
//
// Summary of operation
// - powerdown bit stops regulator, drops power-good
// - after wake, ramp regulator; wait threshold
// - power-good rise resets system, ends isolation
// - bit 4 sets wake output level
// - bit 3 selects wake pin direction
// - input active high; output open-drain low
// - idle wake only while pin is input
// - bit 2 powers down regulators and reference
// - wake pin or alarm re-enables circuits
// - bits 15:5 read zero, ignore writes
// - bit 1 powers down regulators, keeps reference
// - bit 0 enables rtc clock output
`ifndef RTC_PM_REGS_SVH
`define RTC_PM_REGS_SVH

`define PM_REG_ADDR 32'h0000_1930
`define PM_STATUS_ADDR 32'h0000_1934
`define PM_RESET_VALUE 16'h0010
`define PM_BIT_CLKOUT 0
`define PM_BIT_REG_PD 1
`define PM_BIT_REF_PD 2
`define PM_BIT_WAKE_DIR 3
`define PM_BIT_WAKE_LEVEL 4
`define PM_FIELD_MSB 4
`define ST_BIT_VALID 0
`define ST_BIT_ISOLATE 1
`define ST_BIT_WAKE_PIN 2
`define ST_BIT_CAUSE_PIN 3
`define ST_BIT_CAUSE_ALARM 4
`define ST_BIT_STATE_LSB 8
`define WAKE_MIN_NS 30500
`define CLK_PERIOD_NS 25
`define WAKE_MIN_CYCLES ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYS_RESET_CYCLES 16
`define VALID_FILTER_CYCLES 4

`endif

// ==== hw/rtc_pm_pkg.sv ====
// types shared by the power sequencer, its port checker and its bench
// assumes the constants header is included by each user
package rtc_pm_pkg;

  typedef struct packed {
    logic wake_pin_output_level;
    logic wake_pin_direction;
    logic reference_powerdown_bit;
    logic regulator_powerdown_bit;
    logic clock_output_enable;
  } pm_reg_s;

  typedef struct packed {
    logic core_regulator_enable_pin;
    logic por_enable;
    logic bandgap_enable;
  } analog_ctrl_s;

  typedef enum logic [4:0] {
    ST_ON = 5'b0_0001,
    ST_OFF = 5'b0_0010,
    ST_RAMP = 5'b0_0100,
    ST_RELEASE = 5'b0_1000,
    ST_SETTLE = 5'b1_0000
  } seq_state_e;

endpackage : rtc_pm_pkg

// ==== hw/wake_filter.sv ====
// two-flop synchroniser with a minimum high-time qualifier
// assumes pin is asynchronous to clk
`timescale 1ns/1ps
module wake_filter #(
  parameter int MIN_CYCLES = 1220,
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic qualified
);

  logic meta;
  logic [CNT_W-1:0] count;

  // second flop is the only reader of meta
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      qualified <= 1'b0;
    end else if (!level) begin
      count <= '0;
      qualified <= 1'b0;
    end else if (count != CNT_W'(MIN_CYCLES - 1)) begin
      count <= count + CNT_W'(1);
      qualified <= 1'b0;
    end else begin
      qualified <= 1'b1;
    end
  end

endmodule : wake_filter

// ==== testbench/wake_partner.sv ====
// far-side power manager: drives the wake pin high for a set time
// assumes the pin has a pull-up and the open-drain low always wins
`timescale 1ns/1ps
module wake_partner (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] len,
  input wire logic oe,
  output logic pin
);
  logic [15:0] left = 16'h0000;
  always @(posedge clk) begin
    if (go)
      left <= len;
    else if (left != 16'h0000)
      left <= left - 16'h0001;
  end
  assign pin = oe ? 1'b0 : (left != 16'h0000);
endmodule : wake_partner

// ==== testbench/rtc_pm_chk.sv ====
// port checker for the power sequencer
// assumes a bind onto rtc_only_power_sequencer, one clock domain
`timescale 1ns/1ps
module rtc_pm_chk
  import rtc_pm_pkg::*;
#(
  parameter int WAKE_CYCLES = 8,
  parameter int RESET_CYCLES = 4,
  parameter int VALID_CYCLES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wake_pin_i,
  input wire logic wake_pin_o,
  input wire logic wake_pin_oe,
  input wire logic core_regulator_output,
  input wire analog_ctrl_s analog,
  input wire logic supply_valid_signal,
  input wire logic rtc_isolate,
  input wire logic system_reset_n,
  input wire logic idle_wake
);
  logic [15:0] hi_cnt;
  logic [15:0] ok_cnt;
  logic [15:0] rel_cnt;
  // run lengths; the sync stages only add, so lower bounds stay safe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 16'h0000;
      ok_cnt <= 16'h0000;
      rel_cnt <= 16'h0000;
    end else begin
      hi_cnt <= wake_pin_i ? hi_cnt + 16'h0001 : 16'h0000;
      ok_cnt <= core_regulator_output ? ok_cnt + 16'h0001 : 16'h0000;
      rel_cnt <= (supply_valid_signal && !system_reset_n) ? rel_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_drive_low: assert property (wake_pin_o == 1'b0)
    else $error("wake pin driven high");
  chk_isolate_valid: assert property (rtc_isolate == !supply_valid_signal)
    else $error("isolation not opposite of power good");
  chk_reg_off_invalid: assert property (
    !analog.core_regulator_enable_pin |-> !supply_valid_signal)
    else $error("power good with regulator off");
  chk_isolate_por_off: assert property (
    $rose(rtc_isolate) |-> !analog.core_regulator_enable_pin && !analog.por_enable)
    else $error("isolation without shutdown");
  chk_bandgap_pair: assert property (
    !analog.bandgap_enable |-> !analog.core_regulator_enable_pin)
    else $error("bandgap off with regulator on");
  chk_valid_after_ramp: assert property (
    $rose(supply_valid_signal) |-> ok_cnt >= VALID_CYCLES && !system_reset_n)
    else $error("power good too early or without reset");
  chk_release_length: assert property (
    $rose(system_reset_n) |-> rel_cnt >= RESET_CYCLES - 1 && rel_cnt <= RESET_CYCLES + 1)
    else $error("system reset length wrong");
  chk_idle_input_only: assert property (idle_wake |-> !wake_pin_oe)
    else $error("idle wake while pin is output");
  chk_wake_qualify: assert property (idle_wake |-> hi_cnt >= WAKE_CYCLES)
    else $error("wake qualified too soon");
endmodule : rtc_pm_chk

bind rtc_only_power_sequencer rtc_pm_chk #(
  .WAKE_CYCLES(WAKE_CYCLES),
  .RESET_CYCLES(RESET_CYCLES),
  .VALID_CYCLES(VALID_CYCLES)
) chk (
  .clk(clk),
  .rst_n(rst_n),
  .wake_pin_i(wake_pin_i),
  .wake_pin_o(wake_pin_o),
  .wake_pin_oe(wake_pin_oe),
  .core_regulator_output(core_regulator_output),
  .analog(analog),
  .supply_valid_signal(supply_valid_signal),
  .rtc_isolate(rtc_isolate),
  .system_reset_n(system_reset_n),
  .idle_wake(idle_wake)
);

// ==== testbench/rtc_only_power_sequencer_test.sv ====
// self-checking bench for the rtc-only power sequencer
// assumes shortened counts: wake 8, release 4, valid 2
`timescale 1ns/1ps
`include "rtc_pm_regs.svh"
module rtc_only_power_sequencer_test
  import rtc_pm_pkg::*;
;
  typedef struct packed {logic [15:0] wr; logic [15:0] rd; logic oe; logic co;} row_s;
  row_s rows [5] = '{'{16'hffe0, 16'h0000, 1'b0, 1'b0}, '{16'h0018, 16'h0018, 1'b0, 1'b0},
    '{16'h0008, 16'h0008, 1'b1, 1'b0}, '{16'h0001, 16'h0001, 1'b0, 1'b1},
    '{16'h0010, 16'h0010, 1'b0, 1'b0}};
  logic clk = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
  logic reg_ok = 0, rtc_alarm = 0, core_regulator_output = 0;
  logic [31:0] adr_i = '0, dat_i = '0, dat_o, q;
  logic [3:0] sel_i = '0;
  logic [15:0] len = '0;
  logic ack_o, wake_pin_o, wake_pin_oe, wake_pin_i;
  logic supply_valid_signal, rtc_isolate, system_reset_n, clock_out_enable, idle_wake;
  analog_ctrl_s analog;
  int n_mismatch = 0, n_tests = 0, n_wake = 0, cycles = 0, w;

  always #12.5 clk = ~clk;
  wake_partner far (.clk(clk), .go(go), .len(len), .oe(wake_pin_oe), .pin(wake_pin_i));
  rtc_only_power_sequencer #(.WAKE_CYCLES(8), .RESET_CYCLES(4), .VALID_CYCLES(2)) uut (
    .clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .wake_pin_i(wake_pin_i),
    .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe),
    .core_regulator_output(core_regulator_output), .rtc_alarm(rtc_alarm), .analog(analog),
    .supply_valid_signal(supply_valid_signal), .rtc_isolate(rtc_isolate),
    .system_reset_n(system_reset_n), .clock_out_enable(clock_out_enable),
    .idle_wake(idle_wake));

  // comparator follows the regulator only once the ramp is allowed
  always @(posedge clk) begin
    core_regulator_output <= analog.core_regulator_enable_pin & reg_ok;
    cycles <= cycles + 1;
    if (idle_wake === 1'b1)
      n_wake <= n_wake + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task complete_run;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // entered just after a rising edge; holds until ack is sampled
  task bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    int k;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    sel_i <= 4'hf;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk);
    if (k == 20) begin
      n_mismatch++;
      $display("[FAIL] %0t no acknowledge", $time);
    end
  endtask : bus

  task pulse(input logic [15:0] n);
    go <= 1;
    len <= n;
    @(posedge clk);
    go <= 0;
    repeat (40) @(posedge clk);
  endtask : pulse

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    bus(0, `PM_REG_ADDR, 16'h0000);
    cmp(q, 32'h0000_0010);
    foreach (rows[i]) begin
      bus(1, `PM_REG_ADDR, rows[i].wr);
      bus(0, `PM_REG_ADDR, 16'h0000);
      cmp(q, {16'h0000, rows[i].rd});
      cmp({wake_pin_oe, clock_out_enable}, {rows[i].oe, rows[i].co});
    end
    bus(0, 32'h0000_1940, 16'h0000);
    cmp(q, 32'h0000_0000);
    w = n_wake;
    pulse(16'h000e);
    cmp(n_wake, w + 1);
    pulse(16'h0005);
    cmp(n_wake, w + 1);
    bus(1, `PM_REG_ADDR, 16'h0018);
    pulse(16'h000e);
    cmp(n_wake, w + 1);
    // powerdown only while regulators supply the core
    bus(1, `PM_REG_ADDR, 16'h0012);
    repeat (3) @(posedge clk);
    cmp({analog, supply_valid_signal, rtc_isolate, system_reset_n}, 6'b001_010);
    pulse(16'h0005);
    cmp({analog.core_regulator_enable_pin, rtc_isolate}, 2'b01);
    pulse(16'h000e);
    cmp({analog.core_regulator_enable_pin, supply_valid_signal, rtc_isolate}, 3'b101);
    reg_ok <= 1;
    w = 0;
    while (supply_valid_signal !== 1'b1 && w < 50) begin
      @(posedge clk);
      w++;
    end
    cmp({rtc_isolate, system_reset_n}, 2'b00);
    repeat (10) @(posedge clk);
    cmp({supply_valid_signal, rtc_isolate, system_reset_n}, 3'b101);
    bus(0, `PM_REG_ADDR, 16'h0000);
    cmp(q, 32'h0000_0010);
    bus(0, `PM_STATUS_ADDR, 16'h0000);
    cmp(q, 32'h0000_0109);
    bus(1, `PM_STATUS_ADDR, 16'h0008);
    bus(0, `PM_STATUS_ADDR, 16'h0000);
    cmp(q, 32'h0000_0101);
    bus(1, `PM_REG_ADDR, 16'h0014);
    repeat (3) @(posedge clk);
    cmp(analog, 3'b000);
    rtc_alarm <= 1;
    @(posedge clk);
    rtc_alarm <= 0;
    repeat (40) @(posedge clk);
    cmp({supply_valid_signal, system_reset_n}, 2'b11);
    bus(0, `PM_STATUS_ADDR, 16'h0000);
    cmp(q, 32'h0000_0111);
    // mid-run reset taken while shut down
    bus(1, `PM_REG_ADDR, 16'h0012);
    @(posedge clk);
    cmp(rtc_isolate, 1'b1);
    rst_n <= 0;
    repeat (6) @(posedge clk);
    cmp({analog, supply_valid_signal, rtc_isolate, system_reset_n}, 6'b111_101);
    cmp({wake_pin_oe, clock_out_enable, idle_wake}, 3'b000);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    bus(0, `PM_REG_ADDR, 16'h0000);
    cmp(q, 32'h0000_0010);
    bus(0, `PM_STATUS_ADDR, 16'h0000);
    cmp(q, 32'h0000_0101);
    complete_run();
  end
endmodule : rtc_only_power_sequencer_test
